// ### pea_defs.svh
// timing constants for the parallel eeprom host controller
// assumes a 200 MHz clock; every count but the slack derives from the times below
`ifndef PEA_DEFS_SVH
`define PEA_DEFS_SVH

`define PEA_CLK_NS      5
// least write pulse width, ns
`define PEA_T_WP_NS     100
// least address / data hold after the rising strobe, ns
`define PEA_T_AH_NS     50
// longest read access time, ns
`define PEA_T_ACC_NS    120
// longest output float time, ns
`define PEA_T_DF_NS     50
// byte load window, us
`define PEA_T_BLC_US    150
// power-on write lockout, ms
`define PEA_T_POR_MS    5

`define PEA_CYC_WP  ((`PEA_T_WP_NS + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
`define PEA_CYC_AH  ((`PEA_T_AH_NS + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
`define PEA_CYC_ACC ((`PEA_T_ACC_NS + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
`define PEA_CYC_DF  ((`PEA_T_DF_NS + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
`define PEA_CYC_BLC ((`PEA_T_BLC_US * 1000) / `PEA_CLK_NS)
`define PEA_CYC_POR ((`PEA_T_POR_MS * 1000000 + `PEA_CLK_NS - 1) / `PEA_CLK_NS)
// slack kept inside the byte load window for strobe overhead
`define PEA_GAP_SLACK   4
`define PEA_SEQ_DONE    2'h3

`endif

// ### pea_pkg.sv
// types shared by the parallel eeprom host controller
// no constants here; timing lives in pea_defs.svh
package pea_pkg;

    typedef enum logic [1:0] {
        PEA_OP_READ,
        PEA_OP_WRITE,
        PEA_OP_PROT_ON,
        PEA_OP_PROT_OFF
    } pea_op_t;

    typedef enum logic [2:0] {
        ST_LOCK,
        ST_IDLE,
        ST_WR_SET,
        ST_WR_LOW,
        ST_WR_HIGH,
        ST_LOAD,
        ST_RD_LOW,
        ST_RD_END
    } pea_state_t;

endpackage : pea_pkg

// ### pea_timer.sv
// down counter used for strobe phases, byte load window and lockout
// counts one per clock, stops at zero; load wins over counting
`timescale 1ns/100ps

module pea_timer #(
    parameter int           W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              zero
);

    logic [W-1:0] cnt_q;

    // count down to zero and hold there
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= RST_VAL;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign zero = (cnt_q == '0);

endmodule : pea_timer

// ### pea_ctrl.sv
// host-side controller driving a byte-wide parallel eeprom by its pins
// assumes pin inputs synchronous to clk and an external 12 V switch on
// the id line steered by id_access_high_voltage_line
`timescale 1ns/100ps
`include "pea_defs.svh"

module pea_ctrl import pea_pkg::*; #(
    parameter int                BLC_CYC  = `PEA_CYC_BLC,
    parameter int                POR_CYC  = `PEA_CYC_POR,
    parameter logic [15:0]       POLL_MAX = 16'hffff,
    // command sequence addresses and data; values are arbitrary
    parameter logic [2:0][14:0]  SEQ_ADDR = {15'h0003, 15'h0002, 15'h0001},
    parameter logic [2:0][7:0]   SEQ_ON   = {8'h03, 8'h02, 8'h01},
    parameter logic [2:0][7:0]   SEQ_OFF  = {8'h04, 8'h02, 8'h01}
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire pea_op_t     cmd_op,
    input  wire logic [14:0] cmd_addr,
    input  wire logic [7:0]  cmd_data,
    input  wire logic        cmd_last,
    input  wire logic        cmd_unlock,
    input  wire logic        cmd_id,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_error,
    output logic [14:0]      address_lines,
    output logic             chip_sel_n,
    output logic             out_en_n,
    output logic             write_en_n,
    input  wire logic [7:0]  data_lines_in,
    output logic [7:0]       data_lines_out,
    output logic             data_lines_oe_n,
    output logic             id_access_high_voltage_line
);

    pea_state_t  state_q, state_d;
    pea_op_t     op_q, op_sel;
    logic [1:0]  seq_q, seq_d;
    logic [14:0] ua_q, ua_d, addr_q, addr_d;
    logic [7:0]  ud_q, ud_d, dout_q, dout_d, rd_q;
    logic [7:0]  ph_val;
    logic [15:0] poll_cnt_q;
    logic        last_q, unlock_q, poll_q, prev_q, have_prev_q, hv_q;
    logic        ph_zero, gap_zero, por_zero, accept, poll_done, poll_over;

    // strobe phases, byte load window and power-on lockout
    pea_timer #(.W(8)) u_phase (
        .clk      (clk),
        .rst      (rst),
        .load     (state_d != state_q),
        .load_val (ph_val),
        .zero     (ph_zero)
    );
    // window shortened so the next falling strobe still lands inside it
    pea_timer #(.W(16)) u_gap (
        .clk      (clk),
        .rst      (rst),
        .load     (state_d == ST_LOAD && state_q != ST_LOAD),
        .load_val (16'(BLC_CYC - `PEA_CYC_AH - `PEA_GAP_SLACK)),
        .zero     (gap_zero)
    );
    pea_timer #(.W(20), .RST_VAL(20'(POR_CYC))) u_por (
        .clk      (clk),
        .rst      (rst),
        .load     (1'b0),
        .load_val (20'h0_0000),
        .zero     (por_zero)
    );

    // phase length chosen by the state being entered
    always_comb begin
        unique case (state_d)
            ST_WR_LOW:  ph_val = 8'(`PEA_CYC_WP);
            ST_WR_HIGH: ph_val = 8'(`PEA_CYC_AH);
            ST_RD_LOW:  ph_val = 8'(`PEA_CYC_ACC);
            ST_RD_END:  ph_val = 8'(`PEA_CYC_DF);
            default:    ph_val = 8'h00;
        endcase
    end

    // lockout and id voltage changes stall the command port
    always_comb begin
        cmd_ready = 1'b0;
        if (state_q == ST_IDLE) begin
            cmd_ready = (hv_q == cmd_id);
        end else if (state_q == ST_LOAD) begin
            cmd_ready = (cmd_op == PEA_OP_WRITE) && !gap_zero;
        end
    end
    assign accept = cmd_valid && cmd_ready;

    // toggle stopped, and for data writes the top bit is true again
    assign poll_done = have_prev_q && (rd_q[6] == prev_q) &&
                       (op_q != PEA_OP_WRITE || rd_q[7] == dout_q[7]);
    assign poll_over = (poll_cnt_q == POLL_MAX);
    assign op_sel    = (state_q == ST_IDLE && accept) ? cmd_op : op_q;

    // next state and next pin values
    always_comb begin
        state_d = state_q;
        seq_d   = seq_q;
        ua_d    = ua_q;
        ud_d    = ud_q;
        addr_d  = addr_q;
        dout_d  = dout_q;
        unique case (state_q)
            ST_LOCK: begin
                if (por_zero) state_d = ST_IDLE;
            end
            ST_IDLE: begin
                if (accept) begin
                    ua_d = cmd_addr;
                    ud_d = cmd_data;
                    if (cmd_op == PEA_OP_READ) begin
                        addr_d  = cmd_addr;
                        state_d = ST_RD_LOW;
                    end else begin
                        // protected data writes carry the prefix
                        seq_d = (cmd_op == PEA_OP_WRITE && !cmd_unlock) ?
                                `PEA_SEQ_DONE : 2'h0;
                        state_d = ST_WR_SET;
                    end
                end
            end
            ST_WR_SET: state_d = ST_WR_LOW;
            ST_WR_LOW: begin
                if (ph_zero) state_d = ST_WR_HIGH;
            end
            ST_WR_HIGH: begin
                if (ph_zero) begin
                    if (seq_q != `PEA_SEQ_DONE) begin
                        seq_d = seq_q + 2'h1;
                        // a bare command ends after its third write
                        state_d = (seq_q == 2'h2 && op_q != PEA_OP_WRITE) ?
                                  ST_RD_LOW : ST_WR_SET;
                    end else begin
                        state_d = last_q ? ST_RD_LOW : ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin
                if (accept) begin
                    ua_d    = {ua_q[14:6], cmd_addr[5:0]};
                    ud_d    = cmd_data;
                    state_d = ST_WR_SET;
                end else if (gap_zero) begin
                    state_d = ST_RD_LOW;
                end
            end
            ST_RD_LOW: begin
                if (ph_zero) state_d = ST_RD_END;
            end
            ST_RD_END: begin
                if (ph_zero) begin
                    state_d = (!poll_q || poll_done || poll_over) ?
                              ST_IDLE : ST_RD_LOW;
                end
            end
        endcase
        // address and data settle a cycle before the strobe falls
        if (state_d == ST_WR_SET) begin
            if (seq_d != `PEA_SEQ_DONE) begin
                addr_d = SEQ_ADDR[seq_d];
                dout_d = (op_sel == PEA_OP_PROT_OFF) ? SEQ_OFF[seq_d] : SEQ_ON[seq_d];
            end else begin
                addr_d = ua_d;
                dout_d = ud_d;
            end
        end
    end

    // control state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q  <= ST_LOCK;
            seq_q    <= `PEA_SEQ_DONE;
            op_q     <= PEA_OP_READ;
            last_q   <= 1'b0;
            unlock_q <= 1'b0;
            ua_q     <= 15'h0000;
            ud_q     <= 8'h00;
        end else begin
            state_q <= state_d;
            seq_q   <= seq_d;
            ua_q    <= ua_d;
            ud_q    <= ud_d;
            if (accept) begin
                op_q   <= cmd_op;
                last_q <= cmd_last;
            end
            if (accept && state_q == ST_IDLE) unlock_q <= cmd_unlock;
        end
    end

    // pins follow the state being entered, so they are glitch free
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q          <= 15'h0000;
            dout_q          <= 8'h00;
            chip_sel_n      <= 1'b1;
            write_en_n      <= 1'b1;
            out_en_n        <= 1'b1;
            data_lines_oe_n <= 1'b1;
        end else begin
            addr_q          <= addr_d;
            dout_q          <= dout_d;
            chip_sel_n      <= !(state_d inside {ST_WR_SET, ST_WR_LOW, ST_WR_HIGH,
                                                 ST_RD_LOW});
            write_en_n      <= (state_d != ST_WR_LOW);
            out_en_n        <= (state_d != ST_RD_LOW);
            // data held past the rising strobe for the hold time
            data_lines_oe_n <= !(state_d inside {ST_WR_SET, ST_WR_LOW, ST_WR_HIGH});
        end
    end
    assign address_lines  = addr_q;
    assign data_lines_out = dout_q;

    // id voltage moves only in idle while chip select is high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hv_q <= 1'b0;
        end else if (state_q == ST_IDLE && cmd_valid) begin
            hv_q <= cmd_id;
        end
    end
    assign id_access_high_voltage_line = hv_q;

    // end-of-write polling: no fixed wait, the device reports itself
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_q        <= 8'h00;
            poll_q      <= 1'b0;
            prev_q      <= 1'b0;
            have_prev_q <= 1'b0;
            poll_cnt_q  <= 16'h0000;
        end else begin
            if (state_q == ST_RD_LOW && ph_zero) rd_q <= data_lines_in;
            if (state_q == ST_IDLE) begin
                poll_q      <= 1'b0;
                have_prev_q <= 1'b0;
                poll_cnt_q  <= 16'h0000;
            end else if (state_d == ST_RD_LOW && state_q inside {ST_WR_HIGH, ST_LOAD}) begin
                poll_q <= 1'b1;
            end
            if (poll_q && state_q == ST_RD_END && ph_zero) begin
                prev_q      <= rd_q[6];
                have_prev_q <= 1'b1;
                poll_cnt_q  <= poll_cnt_q + 16'h0001;
            end
        end
    end

    // answer once per read or per finished write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
            rsp_error <= 1'b0;
        end else begin
            rsp_valid <= (state_q == ST_RD_END) && (state_d == ST_IDLE);
            rsp_error <= (state_q == ST_RD_END) && (state_d == ST_IDLE) &&
                         poll_q && !poll_done;
            if (state_q == ST_RD_END && state_d == ST_IDLE) rsp_data <= rd_q;
        end
    end

    // helper counters for checks
    logic [15:0] gap_cnt_q;
    logic [2:0]  pre_cnt_q;
    logic        we_n_q;
    // falling strobe found from a registered copy, not a sampled-value call
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_cnt_q <= 16'h0000;
            pre_cnt_q <= 3'h0;
            we_n_q    <= 1'b1;
        end else begin
            we_n_q    <= write_en_n;
            gap_cnt_q <= (!write_en_n || !(state_q inside {ST_LOAD, ST_WR_SET})) ?
                         16'h0000 : gap_cnt_q + 16'h0001;
            if (state_q == ST_IDLE) pre_cnt_q <= 3'h0;
            else if (!write_en_n && we_n_q && pre_cnt_q != 3'h7)
                pre_cnt_q <= pre_cnt_q + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_write_oe_high: assert property (!write_en_n |-> out_en_n && !chip_sel_n)
        else $error("write strobe without chip select or with output enable low");
    chk_no_contention: assert property (!data_lines_oe_n |-> out_en_n)
        else $error("data driven while output enable low");
    chk_page_gap: assert property (gap_cnt_q <= 16'(BLC_CYC))
        else $error("byte load window exceeded");
    chk_page_upper: assert property ($fell(write_en_n) && seq_q == 2'h3 &&
        $past(state_q, 2) == ST_LOAD |-> address_lines[14:6] == ua_q[14:6])
        else $error("page upper address moved");
    chk_unlock_prefix: assert property ($fell(write_en_n) && unlock_q &&
        op_q == PEA_OP_WRITE && seq_q == 2'h3 |-> pre_cnt_q >= 3'h3)
        else $error("protected write without three-write prefix");
    chk_prot_three: assert property ($fell(write_en_n) && op_q != PEA_OP_WRITE &&
        op_q != PEA_OP_READ |-> address_lines == SEQ_ADDR[seq_q])
        else $error("command sequence address wrong");
    chk_hv_stable: assert property ($changed(hv_q) |-> chip_sel_n && $past(chip_sel_n))
        else $error("id voltage moved during an access");
    chk_addr_hold: assert property (!write_en_n && $past(!write_en_n) |->
        $stable(address_lines) && $stable(data_lines_out))
        else $error("address or data moved under write strobe");
    chk_read_answer: assert property (accept && state_q == ST_IDLE &&
        cmd_op == PEA_OP_READ |-> ##[30:45] rsp_valid)
        else $error("read answer late");
    chk_lock_nowrite: assert property (state_q == ST_LOCK |-> write_en_n)
        else $error("write during power-on lockout");

    cov_read: cover property (accept && cmd_op == PEA_OP_READ ##[1:60] rsp_valid);
    cov_page: cover property (state_q == ST_LOAD && accept);
    cov_prot: cover property (op_q == PEA_OP_PROT_ON && rsp_valid && !rsp_error);
    cov_poll_err: cover property (rsp_error);

endmodule : pea_ctrl

// ### pea_eeprom_model.sv
// behavioural byte-wide eeprom answering the host controller's pins
// assumes every strobe lasts several clk cycles, so edges are seen on clk
`timescale 1ns/100ps

module pea_eeprom_model #(
    parameter int               WRITE_CYCLE_TIME  = 200,
    parameter int               BLC  = 64,
    parameter int               LOCK = 20,
    parameter logic [2:0][14:0] SA   = {15'h0003, 15'h0002, 15'h0001},
    parameter logic [2:0][7:0]  SON  = {8'h03, 8'h02, 8'h01},
    parameter logic [2:0][7:0]  SOFF = {8'h04, 8'h02, 8'h01}
) (
    input  wire logic        clk,
    input  wire logic [14:0] address_lines,
    input  wire logic        chip_sel_n,
    input  wire logic        out_en_n,
    input  wire logic        write_en_n,
    input  wire logic [7:0]  data_lines_out,
    input  wire logic        data_lines_oe_n,
    input  wire logic        id_access_high_voltage_line,
    output logic [7:0]       bus,
    output logic [7:0]       viol
);
    logic [7:0]  mem [32768];
    logic [7:0]  idm [64];
    logic [7:0]  pg [64];
    logic [63:0] pg_msk;
    logic [8:0]  pg_hi;
    logic [14:0] lat_a;
    logic [7:0]  last_w, last_drv;
    logic [1:0]  seq_k;
    logic        wr_q, rd_q, pg_id, prot, arm_on, arm_off, tog;
    int          lock_c, blc_c, busy_c;
    wire logic   wr_n = chip_sel_n | write_en_n | ~out_en_n;
    wire logic   rd_n = chip_sel_n | out_en_n | ~write_en_n;
    wire logic   id_rd = id_access_high_voltage_line & (address_lines >= 15'h7fc0);
    wire logic [7:0] arr = id_rd ? idm[address_lines[5:0]] : mem[address_lines];
    // the write cycle runs from the first byte load, so an early poll never sees stale data
    wire logic   in_wr = (busy_c > 0) || (blc_c > 0);
    // busy reads give polling status instead of the array
    wire logic [7:0] rd_v = in_wr ? {~last_w[7], tog, last_w[5:0]} : arr;

    // released lines show the inverse of the last value, never a held copy
    assign bus = !data_lines_oe_n ? data_lines_out : (!rd_n ? rd_v : ~last_drv);

    // shipped blank and unprotected
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        foreach (idm[i]) idm[i] = 8'hff;
        {pg_msk, seq_k, prot, arm_on, arm_off, tog, lock_c, blc_c, busy_c, viol} = '0;
        {last_drv, last_w, lat_a, pg_hi, pg_id} = '0;
        {wr_q, rd_q} = 2'h3;
    end

    // strobe edges, page window and write timer
    always @(posedge clk) begin
        wr_q <= wr_n;
        rd_q <= rd_n;
        if (lock_c < LOCK) lock_c <= lock_c + 1;
        if (busy_c > 0) busy_c <= busy_c - 1;
        if (!rd_n) last_drv <= rd_v;
        if (!rd_n && !data_lines_oe_n) viol <= viol + 8'h01; // both sides driving
        if (rd_q && !rd_n && in_wr) tog <= ~tog;
        if (wr_q && !wr_n) lat_a <= address_lines;
        if (blc_c > 0) blc_c <= blc_c - 1;
        // a strobe that falls inside the window keeps the page open until it rises
        if (wr_q && !wr_n && blc_c > 0) blc_c <= BLC;
        // window lapsed: program the loaded bytes in one go
        if (blc_c == 1) begin
            busy_c <= WRITE_CYCLE_TIME;
            seq_k <= 2'h0;
            arm_on <= 1'b0;
            arm_off <= 1'b0;
            pg_msk <= '0;
            if (arm_on) prot <= 1'b1;
            if (arm_off) prot <= 1'b0;
            // unauthorised writes only run the timer
            if (!prot || seq_k == 2'h3) begin
                for (int i = 0; i < 64; i++) begin
                    if (pg_msk[i] && pg_id) idm[i] <= pg[i];
                    if (pg_msk[i] && !pg_id) mem[{pg_hi, i[5:0]}] <= pg[i];
                end
            end
        end
        // a load: data taken at each rising strobe once lockout ends and no write cycle is busy
        if (!wr_q && wr_n && busy_c == 0 && lock_c >= LOCK) begin
            blc_c <= BLC;
            if (pg_msk != 0 && lat_a[14:6] != pg_hi) viol <= viol + 8'h01;
            if (seq_k != 2'h3 && pg_msk == 0 && lat_a == SA[seq_k]
                && (data_lines_out == SON[seq_k] || data_lines_out == SOFF[seq_k])) begin
                seq_k <= seq_k + 2'h1;
                arm_on <= seq_k == 2'h2 && data_lines_out == SON[2];
                arm_off <= seq_k == 2'h2 && data_lines_out == SOFF[2];
            end else begin
                pg[lat_a[5:0]] <= data_lines_out;
                pg_msk[lat_a[5:0]] <= 1'b1;
                pg_hi <= lat_a[14:6];
                pg_id <= id_access_high_voltage_line & (lat_a >= 15'h7fc0);
                last_w <= data_lines_out;
            end
        end
    end
endmodule : pea_eeprom_model

// ### pea_ctrl_bench.sv
// self-checking bench for the parallel eeprom host controller
// assumes pea_eeprom_model on the pins; short lockout and byte window
`timescale 1ns/100ps

module pea_ctrl_bench import pea_pkg::*;;
    localparam int POR = 20;
    localparam int BLC = 64;
    logic        clk, rst, cmd_valid, cmd_ready, cmd_last, cmd_unlock, cmd_id;
    pea_op_t     cmd_op;
    logic [14:0] cmd_addr, address_lines;
    logic [7:0]  cmd_data, rsp_data, data_lines_out, bus, viol;
    logic        rsp_valid, rsp_error, chip_sel_n, out_en_n, write_en_n;
    logic        data_lines_oe_n, id_line;
    int          n_fail, tests_run, cyc;
    logic [7:0]  rbuf;

    pea_ctrl #(.BLC_CYC(BLC), .POR_CYC(POR), .POLL_MAX(16'h0028)) u_pea_ctrl (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_last(cmd_last),
        .cmd_unlock(cmd_unlock), .cmd_id(cmd_id), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_error(rsp_error), .address_lines(address_lines),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .data_lines_in(bus), .data_lines_out(data_lines_out),
        .data_lines_oe_n(data_lines_oe_n), .id_access_high_voltage_line(id_line));

    pea_eeprom_model #(.BLC(BLC), .LOCK(POR)) u_pea_eeprom_model (
        .clk(clk), .address_lines(address_lines), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_en_n(write_en_n), .data_lines_out(data_lines_out),
        .data_lines_oe_n(data_lines_oe_n), .id_access_high_voltage_line(id_line),
        .bus(bus), .viol(viol));

    // 200 MHz
    always #2.5 clk = ~clk;

    // hang guard, well above the longest polling run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string s);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h want %h", $time, s, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp, input string s);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %b want %b", $time, s, got, exp);
        end
    endtask : check_bit

    // request held until seen accepted; ready is judged between edges
    task automatic issue(input pea_op_t op, input logic [14:0] a, input logic [7:0] d,
                         input logic last, input logic unl, input logic id);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_last <= last;
        cmd_unlock <= unl;
        cmd_id <= id;
        do begin
            @(negedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 5000);
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask : issue

    task automatic get_rsp(output logic [7:0] d);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 5000);
        check_bit(rsp_valid, 1'b1, "answer");
        d = rsp_data;
    endtask : get_rsp

    task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic last,
                      input logic unl, input logic id);
        logic [7:0] r;
        issue(PEA_OP_WRITE, a, d, last, unl, id);
        if (last) begin
            get_rsp(r);
            check_bit(rsp_error, 1'b0, "poll end");
        end
    endtask : wr

    task automatic rd_chk(input logic [14:0] a, input logic id, input logic [7:0] exp);
        logic [7:0] r;
        issue(PEA_OP_READ, a, 8'h00, 1'b0, 1'b0, id);
        get_rsp(r);
        check_byte(r, exp, "read");
    endtask : rd_chk

    // reads wait out the lockout, then see blank array
    task automatic t_power();
        int n;
        logic [7:0] r;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check_bit(n >= POR - 3, 1'b1, "lockout");
        @(posedge clk);
        cmd_valid <= 1'b0;
        // the request held through lockout is a real read of address zero
        get_rsp(r);
        check_byte(r, 8'hff, "blank");
        rd_chk(15'h0123, 1'b0, 8'hff);
    endtask : t_power

    initial begin
        {clk, cmd_valid, cmd_last, cmd_unlock, cmd_id, cmd_addr, cmd_data} = '0;
        cmd_op = PEA_OP_READ;
        rst = 1'b1;
        {n_fail, tests_run, cyc} = '0;
        repeat (6) @(posedge clk);
        check_bit(chip_sel_n & write_en_n & out_en_n & data_lines_oe_n, 1'b1, "idle");
        check_bit(cmd_ready, 1'b0, "ready");
        rst <= 1'b0;
        t_power();
        // back-to-back byte writes
        wr(15'h0140, 8'h3c, 1'b1, 1'b0, 1'b0);
        wr(15'h0141, 8'hc3, 1'b1, 1'b0, 1'b0);
        rd_chk(15'h0140, 1'b0, 8'h3c);
        rd_chk(15'h0141, 1'b0, 8'hc3);
        // page: out of order, a reload, stray upper bits
        wr(15'h0285, 8'h11, 1'b0, 1'b0, 1'b0);
        wr(15'h7f81, 8'h22, 1'b0, 1'b0, 1'b0);
        wr(15'h0285, 8'h33, 1'b0, 1'b0, 1'b0);
        wr(15'h02bf, 8'h44, 1'b1, 1'b0, 1'b0);
        rd_chk(15'h0285, 1'b0, 8'h33);
        rd_chk(15'h0281, 1'b0, 8'h22);
        rd_chk(15'h02bf, 1'b0, 8'h44);
        rd_chk(15'h0282, 1'b0, 8'hff);
        rd_chk(15'h7f81, 1'b0, 8'hff);
        // page left open until the window lapses
        wr(15'h0300, 8'h5a, 1'b0, 1'b0, 1'b0);
        get_rsp(rbuf);
        check_bit(rsp_error, 1'b0, "lapse end");
        rd_chk(15'h0300, 1'b0, 8'h5a);
        // protection on, bare and prefixed writes, then off
        issue(PEA_OP_PROT_ON, 15'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
        get_rsp(rbuf);
        check_bit(rsp_error, 1'b0, "protect on end");
        wr(15'h0400, 8'ha5, 1'b1, 1'b0, 1'b0);
        rd_chk(15'h0400, 1'b0, 8'hff);
        wr(15'h0401, 8'h96, 1'b1, 1'b1, 1'b0);
        rd_chk(15'h0401, 1'b0, 8'h96);
        rd_chk(15'h0001, 1'b0, 8'hff);
        issue(PEA_OP_PROT_OFF, 15'h0000, 8'h00, 1'b0, 1'b0, 1'b0);
        get_rsp(rbuf);
        check_bit(rsp_error, 1'b0, "protect off end");
        rd_chk(15'h0003, 1'b0, 8'hff);
        wr(15'h0402, 8'h69, 1'b1, 1'b0, 1'b0);
        rd_chk(15'h0402, 1'b0, 8'h69);
        // id area only under high voltage
        wr(15'h7fc5, 8'h4b, 1'b1, 1'b0, 1'b1);
        rd_chk(15'h7fc5, 1'b1, 8'h4b);
        rd_chk(15'h7fc5, 1'b0, 8'hff);
        check_byte(viol, 8'h00, "pin conflicts");
        print_verdict();
    end
endmodule : pea_ctrl_bench
